// ===== hdl/cbp_pkg.sv
package cbp_pkg;
    // Power level encodings
    localparam logic [1:0] CBP_D0 = 2'h0;
    localparam logic [1:0] CBP_D1 = 2'h1;
    localparam logic [1:0] CBP_D2 = 2'h2;
    localparam logic [1:0] CBP_D3 = 2'h3;

    // Register byte offsets
    localparam logic [3:0] CBP_OFS_PM_CONTROL_STATUS_REGISTER  = 4'h0;  // Power control/status
    localparam logic [3:0] CBP_OFS_CMD    = 4'h4;  // Window and master enables
    localparam logic [3:0] CBP_OFS_CTX    = 4'h8;  // Controller context (window base)
    localparam logic [3:0] CBP_OFS_SLOT   = 4'hC;  // Slot supply control and status

    // Control/status register field positions
    localparam int CBP_PM_LVL_LSB   = 0;   // Power level field, two bits
    localparam int CBP_PM_WAKE_EN   = 8;   // Wake enable
    localparam int CBP_PM_WAKE_ST   = 15;  // Wake status, write one to clear
    localparam int CBP_PM_AUX       = 16;  // Auxiliary power present (read only)
    localparam int CBP_PM_ACTIVE    = 17;  // Active D0 indication (read only)

    // Command register bits
    localparam int CBP_CMD_IO  = 0;
    localparam int CBP_CMD_MEM = 1;
    localparam int CBP_CMD_BM  = 2;

    // Slot register bits
    localparam int CBP_SLOT_PWR    = 0;  // Slot supply on
    localparam int CBP_SLOT_DETECT = 8;  // Card present (read only)

    // Reset values
    localparam logic [31:0] CBP_CTX_RST  = 32'h0000_0000;
    localparam logic        CBP_SLOT_RST = 1'b0;

    // Event and gating outputs bundled
    typedef struct packed {
        logic csc_irq;    // Status-change interrupt to processor
        logic func_irq;   // Card functional interrupt to processor
        logic pme;        // Wake request, active high internally
    } cbp_evt_t;

    typedef struct packed {
        logic clk_run;    // Socket clock running
        logic bus_idle;   // Slot bus held idle
        logic ctl_ok;     // Controller interface usable
        logic slot_pwr;   // Slot supply enabled
    } cbp_slot_t;
endpackage

// ===== hdl/cbp_sync.sv
`timescale 1ns/1ps
// Three-stage input synchroniser; value moves when stages two and three agree
module cbp_sync
    import cbp_pkg::*;
(
    // Clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    // Data
    input  wire logic async_i,
    output logic      sync_o
);
    logic s1_q;  // Metastability stage, read by s2 only
    logic s2_q;
    logic s3_q;

    // Shift chain and agreement filter
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            s1_q   <= 1'b0;
            s2_q   <= 1'b0;
            s3_q   <= 1'b0;
            sync_o <= 1'b0;
        end else begin
            s1_q <= async_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                sync_o <= s3_q;
            end
        end
    end
endmodule

// ===== hdl/cbp_top.sv
`timescale 1ns/1ps
// What this block does
// RULE_01: D0 passes status-change and functional interrupts; the code holds csc_irq_o low in D0 while wake_en_q is set
// RULE_02: Accept only permitted power state transitions
// RULE_03: Status change raises wake when enabled; the code raises it only in D1, D2 and aux-powered D3, never in D0
// RULE_04: No functional interrupts in D1, D2
// RULE_05: Context kept in D1/D2, D0-only access
// RULE_06: Config readable; power level stays writable; the code ignores every level write made in D3
// RULE_07: D1 keeps clock unless clock-run stops it
// RULE_08: D2 stops socket clock, bus idle
// RULE_09: D1 status change asserts wake output
// RULE_10: D0/D1 forward status change, card unpowered; the code forwards it only while wake_en_q is clear
// RULE_11: D3 without wake generates no wake
// RULE_12: D3 without wake loses context, clock off
// RULE_13: D3 wake keeps only wake context; the code also keeps the controller context ctx_q in D3 with wake
// RULE_14: D3 wake removal turns slot power off
// RULE_15: Slot power available in D0 through D2
// RULE_16: Bus reset after D3 gives full reset; the code keeps wake context and slot_pwr_q when wake_en_q was set
// RULE_17: Reset restores defaults, wake context kept; the code keeps wake context and slot_pwr_q only if wake_en_q was set
// RULE_18: Enables move uninitialised D0 to active
// RULE_19: Controller interface refused in D1, D2
// RULE_20: D3 blocks card access entirely
// RULE_21: Unsupported state write ignored, state kept
// RULE_22: Status bits change after state change done
// RULE_23: Two-bit power level, D0 to D3
module cbp_top
    import cbp_pkg::*;
#(
    parameter int SETTLE_CYC = 4  // Cycles to carry out a state change
)
(
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Power and socket pins
    input  wire logic        aux_power_i,
    input  wire logic        card_status_change_line_i,
    input  wire logic        card_detect_i,
    input  wire logic        card_func_irq_i,
    input  wire logic        clk_run_stop_i,
    // Outputs to system
    output logic             csc_irq_o,
    output logic             func_irq_o,
    output logic             pme_n_o,
    // Outputs to socket
    output logic             socket_clock_en_o,
    output logic             slot_bus_idle_o,
    output logic             slot_power_o,
    output logic             ctl_iface_ok_o
);
    localparam int SET_W = $clog2(SETTLE_CYC + 1);

    // Synchronised pin levels
    logic aux_s;
    logic csc_s;
    logic det_s;
    logic fir_s;
    logic crs_s;

    // Power state and pending request
    logic [1:0]       lvl_q;        // Reported power level
    logic [1:0]       tgt_q;        // Requested target level
    logic             busy_q;       // State change in progress
    logic [SET_W-1:0] cnt_q;        // Settle counter
    logic             wake_en_q;    // Wake enable (wake context)
    logic             wake_st_q;    // Wake status (wake context)
    logic             csc_prev_q;   // Previous status-change level
    logic             det_prev_q;   // Previous card-detect level
    logic [2:0]       cmd_q;        // IO, memory, master enables
    logic [31:0]      ctx_q;        // Controller context word
    logic             slot_pwr_q;   // Slot supply control
    logic             ack_q;        // Bus answer strobe
    logic             cold_q = 1'b0; // Set once a reset has released; power-up clear

    // Synchronisers for every pin input
    cbp_sync u_s_aux (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .async_i(aux_power_i),
                      .sync_o(aux_s));
    cbp_sync u_s_csc (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
                      .async_i(card_status_change_line_i), .sync_o(csc_s));
    cbp_sync u_s_det (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .async_i(card_detect_i),
                      .sync_o(det_s));
    cbp_sync u_s_fir (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .async_i(card_func_irq_i),
                      .sync_o(fir_s));
    cbp_sync u_s_crs (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .async_i(clk_run_stop_i),
                      .sync_o(crs_s));

    // State decodes
    wire in_d0      = (lvl_q == CBP_D0);
    wire in_d1      = (lvl_q == CBP_D1);
    wire in_d2      = (lvl_q == CBP_D2);
    wire in_d3      = (lvl_q == CBP_D3);
    wire d3_wake    = in_d3 && aux_s && wake_en_q;
    wire active_d0  = in_d0 && (cmd_q != 3'h0);               // RULE_18
    wire csc_edge   = csc_s && !csc_prev_q;
    wire removal    = det_prev_q && !det_s;

    // Bus decode
    wire req        = (avs_read_i || avs_write_i) && !ack_q;
    wire wr         = avs_write_i && !ack_q;
    wire sel_pm     = (avs_address_i == CBP_OFS_PM_CONTROL_STATUS_REGISTER);
    wire sel_cmd    = (avs_address_i == CBP_OFS_CMD);
    wire sel_ctx    = (avs_address_i == CBP_OFS_CTX);
    wire sel_slot   = (avs_address_i == CBP_OFS_SLOT);
    wire ctx_open   = in_d0;                                  // RULE_05 RULE_19 RULE_20
    wire wr_pm_lo   = wr && sel_pm && avs_byteenable_i[0];    // RULE_06
    wire wr_pm_hi   = wr && sel_pm && avs_byteenable_i[1];
    wire [1:0] req_lvl = avs_writedata_i[CBP_PM_LVL_LSB +: 2]; // RULE_23

    // Permitted transitions; D3 leaves only through bus reset
    wire path_ok =
        (in_d0 && (req_lvl != CBP_D0)) ||
        (in_d1 && (req_lvl != CBP_D1)) ||
        (in_d2 && ((req_lvl == CBP_D0) || (req_lvl == CBP_D3)));  // RULE_02
    wire start_chg = wr_pm_lo && path_ok && !busy_q;           // RULE_21

    // Wake source: status change in D1, D2 or aux-powered D3
    wire wake_state = in_d1 || in_d2 || (in_d3 && aux_s);      // RULE_03 RULE_11
    wire wake_set   = wake_state && wake_en_q && csc_edge;      // RULE_09
    wire wake_clr   = wr_pm_hi && avs_writedata_i[CBP_PM_WAKE_ST];

    // Read data mux
    wire [31:0] pm_rd = {14'h0, active_d0, aux_s, wake_st_q, 6'h0, wake_en_q, 6'h0, lvl_q};
    wire [31:0] rd_mux =
        sel_pm   ? pm_rd :
        sel_cmd  ? {29'h0, cmd_q} :
        (sel_ctx && ctx_open)  ? ctx_q :
        sel_slot ? {23'h0, det_s, 7'h0, slot_pwr_q} : 32'h0;

    // Event and socket decodes
    cbp_evt_t  evt_d;
    cbp_slot_t slt_d;
    assign evt_d.csc_irq  = (in_d0 || in_d1) && csc_s && !wake_en_q; // RULE_01 RULE_10
    assign evt_d.func_irq = in_d0 && fir_s;                          // RULE_01 RULE_04
    assign evt_d.pme      = wake_st_q && wake_en_q;
    assign slt_d.clk_run  = in_d0 || (in_d1 && !crs_s);              // RULE_07 RULE_08 RULE_12
    assign slt_d.bus_idle = !in_d0;                                  // RULE_07 RULE_08
    assign slt_d.ctl_ok   = in_d0;                                   // RULE_19 RULE_20
    assign slt_d.slot_pwr = slot_pwr_q && !in_d3 ? 1'b1 : slot_pwr_q; // RULE_15

    // Bus handshake: one wait cycle then acknowledge, waitrequest from a flop
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ack_q             <= 1'b0;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h0;
        end else begin
            ack_q             <= req;
            avs_waitrequest_o <= !req;
            if (req) begin
                avs_readdata_o <= rd_mux;
            end
        end
    end

    // Power level sequencing; status updated after settle time
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            lvl_q  <= CBP_D0;                                  // RULE_16 RULE_17
            tgt_q  <= CBP_D0;
            busy_q <= 1'b0;
            cnt_q  <= '0;
        end else if (start_chg) begin
            tgt_q  <= req_lvl;
            busy_q <= 1'b1;
            cnt_q  <= SET_W'(SETTLE_CYC);
        end else if (busy_q) begin
            if (cnt_q == '0) begin
                lvl_q  <= tgt_q;                               // RULE_22
                busy_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    // Wake context: survives bus reset when wake was enabled
    // Warm marker is not cleared by bus reset, so a long reset keeps context
    always_ff @(posedge clk_sys_i) begin
        if (rst_n_i) begin
            cold_q <= 1'b1;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i && !(cold_q && wake_en_q)) begin
            wake_en_q <= 1'b0;                                 // RULE_17
            wake_st_q <= 1'b0;
        end else if (rst_n_i) begin
            if (wr_pm_hi) begin
                wake_en_q <= avs_writedata_i[CBP_PM_WAKE_EN];
            end
            if (wake_set) begin
                wake_st_q <= 1'b1;                             // RULE_03 RULE_13
            end else if (wake_clr) begin
                wake_st_q <= 1'b0;
            end
        end
    end

    // Edge trackers
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            csc_prev_q <= 1'b0;
            det_prev_q <= 1'b0;
        end else begin
            csc_prev_q <= csc_s;
            det_prev_q <= det_s;
        end
    end

    // Command enables, writable in D0 only
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            cmd_q <= 3'h0;
        end else if (wr && sel_cmd && avs_byteenable_i[0] && in_d0) begin
            cmd_q <= avs_writedata_i[CBP_CMD_BM:CBP_CMD_IO];   // RULE_18
        end
    end

    // Controller context: kept in D1/D2, lost in D3 without wake
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ctx_q <= CBP_CTX_RST;
        end else if (in_d3 && !d3_wake) begin
            ctx_q <= CBP_CTX_RST;                              // RULE_12 RULE_13
        end else if (wr && sel_ctx && ctx_open) begin
            ctx_q <= avs_writedata_i;                          // RULE_05
        end
    end

    // Slot supply control
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i && !(cold_q && wake_en_q)) begin
            slot_pwr_q <= CBP_SLOT_RST;
        end else if (rst_n_i) begin
            if (d3_wake && removal) begin
                slot_pwr_q <= 1'b0;                            // RULE_14
            end else if (wr && sel_slot && avs_byteenable_i[0] && in_d0) begin
                slot_pwr_q <= avs_writedata_i[CBP_SLOT_PWR];
            end
        end
    end

    // Registered outputs
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            csc_irq_o         <= 1'b0;
            func_irq_o        <= 1'b0;
            pme_n_o           <= 1'b1;
            socket_clock_en_o <= 1'b0;
            slot_bus_idle_o   <= 1'b1;
            slot_power_o      <= 1'b0;
            ctl_iface_ok_o    <= 1'b0;
        end else begin
            csc_irq_o         <= evt_d.csc_irq;
            func_irq_o        <= evt_d.func_irq;
            pme_n_o           <= !evt_d.pme;                 // RULE_09 RULE_11
            socket_clock_en_o <= slt_d.clk_run;
            slot_bus_idle_o   <= slt_d.bus_idle;
            slot_power_o      <= slt_d.slot_pwr;             // RULE_15
            ctl_iface_ok_o    <= slt_d.ctl_ok;
        end
    end
endmodule

// ===== sim/cbp_top_properties.sv
`timescale 1ns/1ps
// Port-level checks for the power-state block
module cbp_top_properties
    import cbp_pkg::*;
#(
    parameter int SETTLE_CYC = 4  // Cycles to carry out a state change
)
(
    // Clock and reset
    input wire logic        clk_sys_i,
    input wire logic        rst_n_i,
    // Register bus
    input wire logic [3:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    // Block outputs
    input wire logic        csc_irq_o,
    input wire logic        func_irq_o,
    input wire logic        pme_n_o,
    input wire logic        socket_clock_en_o,
    input wire logic        slot_bus_idle_o,
    input wire logic        ctl_iface_ok_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // Request taken by the slave
    sequence s_take;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    // Level write that leaves D0
    sequence s_leave;
        s_take ##0 (avs_write_i && avs_address_i == CBP_OFS_PM_CONTROL_STATUS_REGISTER && avs_byteenable_i[0]
            && avs_writedata_i[1:0] != CBP_D0 && ctl_iface_ok_o);
    endsequence
    AST_WAIT_ONE: assert property (s_take |=> !avs_waitrequest_o)
        else $error("answer not one cycle after request");
    AST_WAIT_PULSE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    AST_HOLD_DATA: assert property (!avs_waitrequest_o ##1 !(avs_read_i || avs_write_i)
        |-> $stable(avs_readdata_o)) else $error("read data moved while idle");
    AST_IDLE_D0: assert property (slot_bus_idle_o == !ctl_iface_ok_o)
        else $error("slot bus idle disagrees with controller state");
    AST_FUNC_GATE: assert property (func_irq_o |-> ctl_iface_ok_o)
        else $error("functional interrupt outside D0");
    AST_CLK_D0: assert property (ctl_iface_ok_o |-> socket_clock_en_o)
        else $error("socket clock stopped in D0");
    AST_CSC_WAKE: assert property (!pme_n_o |-> !csc_irq_o)
        else $error("status interrupt while wake asserted");
    AST_SETTLE: assert property (s_leave |=> ctl_iface_ok_o [*2])
        else $error("state left before change carried out");
    AST_LEAVE: assert property (s_leave |-> ##[2:12] !ctl_iface_ok_o)
        else $error("permitted state change not made");
endmodule

bind cbp_top cbp_top_properties #(.SETTLE_CYC(SETTLE_CYC)) u_props (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .csc_irq_o(csc_irq_o), .func_irq_o(func_irq_o),
    .pme_n_o(pme_n_o), .socket_clock_en_o(socket_clock_en_o),
    .slot_bus_idle_o(slot_bus_idle_o), .ctl_iface_ok_o(ctl_iface_ok_o));

// ===== sim/cbp_wake_mdl.sv
`timescale 1ns/1ps
// Host wake logic: counts wake requests on the active-low line
module cbp_wake_mdl
(
    // Clock and reset
    input  wire logic  clk_sys_i,
    input  wire logic  rst_n_i,
    // Wake request from bridge
    input  wire logic  pme_n_i,
    // Wake requests seen
    output logic [7:0] wake_cnt_o
);
    logic pme_n_q;  // Previous line level
    // Count each falling edge of the wake line
    always_ff @(posedge clk_sys_i) begin
        pme_n_q <= pme_n_i;
        if (!rst_n_i) begin
            wake_cnt_o <= 8'h00;
        end else if (pme_n_q && !pme_n_i) begin
            wake_cnt_o <= wake_cnt_o + 8'h01;
        end
    end
endmodule

// ===== sim/tb.sv
`timescale 1ns/1ps
// Register-level test of the power-state block
module tb;
    import cbp_pkg::*;
    logic        clk_sys_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [3:0]  avs_address_i = 4'h0;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        aux_power_i = 1'b1;
    logic        csl_i = 1'b0;  // Card status-change line
    logic        card_detect_i = 1'b1;
    logic        card_func_irq_i = 1'b0;
    logic        clk_run_stop_i = 1'b0;
    logic        csc_irq_o, func_irq_o, pme_n_o, socket_clock_en_o;
    logic        slot_bus_idle_o, slot_power_o, ctl_iface_ok_o;
    logic [7:0]  wake_cnt;
    logic [31:0] q;
    int          num_errors = 0;
    int          cmp_count = 0;

    cbp_top dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .aux_power_i(aux_power_i),
        .card_status_change_line_i(csl_i), .card_detect_i(card_detect_i),
        .card_func_irq_i(card_func_irq_i), .clk_run_stop_i(clk_run_stop_i),
        .csc_irq_o(csc_irq_o), .func_irq_o(func_irq_o), .pme_n_o(pme_n_o),
        .socket_clock_en_o(socket_clock_en_o), .slot_bus_idle_o(slot_bus_idle_o),
        .slot_power_o(slot_power_o), .ctl_iface_ok_o(ctl_iface_ok_o));
    cbp_wake_mdl u_host (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .pme_n_i(pme_n_o),
        .wake_cnt_o(wake_cnt));

    // Clock at 40 MHz
    initial begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    // Compare and count
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    // One bus cycle, held until waitrequest is low
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= !w;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        if (n >= 50) num_errors++;
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask

    // Settle time covers input sync and state change
    task settle();
        repeat (12) @(posedge clk_sys_i);
    endtask

    // Write then wait for the change to land
    task wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
        settle();
    endtask

    // Read power register, active-D0 bit masked
    task rpm(input logic [31:0] e);
        bus(1'b0, CBP_OFS_PM_CONTROL_STATUS_REGISTER, 32'h0);
        chk("pm", q & 32'h0001_8103, e);
    endtask

    // Bus reset held six cycles
    task bus_reset();
        @(posedge clk_sys_i);
        rst_n_i <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        settle();
    endtask

    // Verdict and end of run
    task summarize();
        $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        num_errors++;
        summarize();
    end

    // Main sequence
    initial begin
        repeat (6) @(posedge clk_sys_i);
        chk("idle", slot_bus_idle_o, 1);
        chk("pme_n", pme_n_o, 1);
        rst_n_i <= 1'b1;
        settle();
        bus(1'b0, CBP_OFS_PM_CONTROL_STATUS_REGISTER, 32'h0);
        chk("pm", q & 32'h0003_0103, 32'h0001_0000);
        wr(CBP_OFS_CMD, 32'h2);
        bus(1'b0, CBP_OFS_PM_CONTROL_STATUS_REGISTER, 32'h0);
        chk("active", q[CBP_PM_ACTIVE], 1);
        wr(CBP_OFS_CTX, 32'hA5A5_5A5A);
        wr(CBP_OFS_SLOT, 32'h1);
        card_func_irq_i <= 1'b1;
        csl_i <= 1'b1;
        settle();
        chk("func", func_irq_o, 1);
        chk("csc", csc_irq_o, 1);
        chk("slot_pwr", slot_power_o, 1);
        $display("test d0 done");
        wr(CBP_OFS_PM_CONTROL_STATUS_REGISTER, 32'h1);
        rpm(32'h0001_0001);
        chk("func", func_irq_o, 0);
        chk("csc", csc_irq_o, 1);
        chk("clk", socket_clock_en_o, 1);
        bus(1'b0, CBP_OFS_CTX, 32'h0);
        chk("ctx", q, 32'h0);
        clk_run_stop_i <= 1'b1;
        settle();
        chk("clk", socket_clock_en_o, 0);
        clk_run_stop_i <= 1'b0;
        wr(CBP_OFS_PM_CONTROL_STATUS_REGISTER, 32'h2);
        chk("clk", socket_clock_en_o, 0);
        chk("slot_pwr", slot_power_o, 1);
        wr(CBP_OFS_PM_CONTROL_STATUS_REGISTER, 32'h1);
        rpm(32'h0001_0002);
        wr(CBP_OFS_PM_CONTROL_STATUS_REGISTER, 32'h0);
        bus(1'b0, CBP_OFS_CTX, 32'h0);
        chk("ctx", q, 32'hA5A5_5A5A);
        csl_i <= 1'b0;
        $display("test states done");
        wr(CBP_OFS_PM_CONTROL_STATUS_REGISTER, 32'h101);
        csl_i <= 1'b1;
        settle();
        chk("pme_n", pme_n_o, 0);
        chk("wakes", wake_cnt, 1);
        rpm(32'h0001_8101);
        csl_i <= 1'b0;
        wr(CBP_OFS_PM_CONTROL_STATUS_REGISTER, 32'h8101);
        chk("pme_n", pme_n_o, 1);
        wr(CBP_OFS_PM_CONTROL_STATUS_REGISTER, 32'h103);
        chk("ctl", ctl_iface_ok_o, 0);
        csl_i <= 1'b1;
        card_detect_i <= 1'b0;
        settle();
        chk("pme_n", pme_n_o, 0);
        chk("slot_pwr", slot_power_o, 0);
        csl_i <= 1'b0;
        bus_reset();
        rpm(32'h0001_8100);
        bus(1'b0, CBP_OFS_SLOT, 32'h0);
        chk("slot", q[CBP_SLOT_PWR], 0);
        $display("test wake done");
        wr(CBP_OFS_PM_CONTROL_STATUS_REGISTER, 32'h8000);
        wr(CBP_OFS_PM_CONTROL_STATUS_REGISTER, 32'h3);
        csl_i <= 1'b1;
        settle();
        chk("pme_n", pme_n_o, 1);
        wr(CBP_OFS_PM_CONTROL_STATUS_REGISTER, 32'h0);
        rpm(32'h0001_0003);
        csl_i <= 1'b0;
        bus_reset();
        rpm(32'h0001_0000);
        bus(1'b0, CBP_OFS_CTX, 32'h0);
        chk("ctx", q, 32'h0);
        $display("test d3 done");
        summarize();
    end
endmodule
